/* File: src/dtc_cfg.svh */
/*
 * Constants for the dual timer/counter block: register addresses, control
 * and mode bit positions, reset values and timing figures.
 * Assumes a single 50 MHz core clock and an 8-bit register port.
 */
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// Register addresses
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_TL0 8'h8a
`define DTC_ADDR_TL1 8'h8b
`define DTC_ADDR_TH0 8'h8c
`define DTC_ADDR_TH1 8'h8d
// Vector acknowledge address (not decoded; acknowledges come in on the vec_ack port)
`define DTC_ADDR_VACK 8'h8e

// Control register bit positions
`define DTC_CTRL_OVF1 7
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_EXF1 3
`define DTC_CTRL_EDG1 2
`define DTC_CTRL_EXF0 1
`define DTC_CTRL_EDG0 0

// Mode register: upper nibble timer one, lower nibble timer zero
`define DTC_MODE_GATE 3
`define DTC_MODE_CSEL 2
`define DTC_MODE_FHI 1
`define DTC_MODE_FLO 0
`define DTC_NIB1 4

// Vector acknowledge bits: timer0, ext0, timer1, ext1
`define DTC_VACK_T0 0
`define DTC_VACK_E0 1
`define DTC_VACK_T1 2
`define DTC_VACK_E1 3

// Reset value for all registers
`define DTC_RST_BYTE 8'h00

// Mode 0 prescaler width (divide by 32) and mask of its low bits
`define DTC_PRE_MASK 8'h1f
`define DTC_PRE_TOP 8'h1f
`define DTC_BYTE_TOP 8'hff

// Core clock cycles per machine cycle
`define DTC_MC_CYCLES 12
`define DTC_MC_W 4

`endif

/* File: src/dtc_pkg.sv */
/*
 * Types for the dual timer/counter block.
 * Assumes dtc_cfg.svh is included for numeric constants.
 */
package dtc_pkg;

    // Timer mode field values
    typedef enum logic [1:0] {
        DTC_M13,
        DTC_M16,
        DTC_M8R,
        DTC_MSPLIT
    } dtc_mode_type;

    // Complete state of the block
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [7:0] rdata;
        logic [3:0] mc_cnt;
        logic mc_tick;
        logic [1:0] irq_s1;
        logic [1:0] irq_s2;
        logic [1:0] irq_d;
        logic [1:0] cnt_s1;
        logic [1:0] cnt_s2;
        logic [1:0] cnt_d;
        logic ovf_t0;
        logic ovf_t1;
        logic baud_ovf;
    } dtc_state_type;

endpackage

/* File: src/dtc_timer.sv */
/*
 * Dual timer/counter with shared run and external interrupt control.
 * Assumes an 8-bit register port with read data one cycle after the read
 * strobe, and asynchronous pins that are synchronised here.
 */
// Decided for this implementation: the address-and-strobe port.
// Operation
// - Each timer is two byte registers
// - Timer one overflow sets bit 7, vector clears
// - Timer zero overflow sets bit 5, vector clears
// - Run bits 6 and 4 start timers
// - Ext flags set by edge or level
// - Trigger bits pick edge or level
// - Low control bits never affect counting
// - Mode 0 uses divide-by-32 prescaler
// - Mode 0 count is 13 bits
// - Wrap to zero sets overflow flag
// - Outside split mode, count only when run and gate allow
// - Setting run keeps count contents
// - Mode 1 is full 16-bit count
// - Mode 2 reloads low from high
// - Timer one mode 3 holds count
// - Split mode high byte uses timer one controls
// - Split mode timer one runs without flag
// - Counter select picks pin or clock
// - Two-bit mode field selects mode
// - Gate bit needs pin high to run
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module dtc_timer #(
    parameter int MC_CYCLES = `DTC_MC_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [3:0] vec_ack,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    output logic ovf_flag_zero,
    output logic ovf_flag_one,
    output logic extint_flag_zero,
    output logic extint_flag_one,
    output logic baud_ovf
);

    dtc_pkg::dtc_state_type state; // Registered state
    dtc_pkg::dtc_state_type next_state; // Next value of the state

    // Result of one increment step on a byte
    typedef struct packed {
        logic [7:0] val;
        logic wrap;
    } dtc_inc_type;

    // Increment a byte whose count wraps at top
    function automatic dtc_inc_type dtc_inc(input logic [7:0] v,
                                            input logic [7:0] top,
                                            input logic en);
        dtc_inc_type r;
        r.val = v;
        r.wrap = 1'b0;
        if (en) begin
            if ((v & top) == top) begin
                r.val = v & ~top;
                r.wrap = 1'b1;
            end else begin
                r.val = 8'((v & top) + 8'h01) | (v & ~top);
            end
        end
        return r;
    endfunction

    // Whether a timer's count source ticks this cycle
    function automatic logic dtc_tick(input logic [3:0] nib,
                                      input logic run,
                                      input logic pin,
                                      input logic mc,
                                      input logic fall);
        logic src;
        src = nib[`DTC_MODE_CSEL] ? fall : mc;
        return run && (!nib[`DTC_MODE_GATE] || pin) && src;
    endfunction

    // Step a byte pair in modes 0 to 2; split handled by caller
    function automatic logic [16:0] dtc_step(input logic [1:0] m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi,
                                             input logic en);
        dtc_inc_type l;
        dtc_inc_type h;
        logic [7:0] nlo;
        logic [7:0] nhi;
        logic ov;
        nlo = lo;
        nhi = hi;
        ov = 1'b0;
        unique case (dtc_pkg::dtc_mode_type'(m))
            dtc_pkg::DTC_M13: begin
                // Low five bits prescale by 32, high byte counts
                l = dtc_inc(lo, `DTC_PRE_TOP, en);
                h = dtc_inc(hi, `DTC_BYTE_TOP, l.wrap);
                nlo = l.val;
                nhi = h.val;
                ov = h.wrap;
            end
            dtc_pkg::DTC_M16: begin
                // Both bytes cascaded
                l = dtc_inc(lo, `DTC_BYTE_TOP, en);
                h = dtc_inc(hi, `DTC_BYTE_TOP, l.wrap);
                nlo = l.val;
                nhi = h.val;
                ov = h.wrap;
            end
            dtc_pkg::DTC_M8R: begin
                // Low byte counts, reloads from high
                l = dtc_inc(lo, `DTC_BYTE_TOP, en);
                nlo = l.wrap ? hi : l.val;
                ov = l.wrap;
            end
            dtc_pkg::DTC_MSPLIT: begin
                // Caller handles split and hold
                nlo = lo;
            end
        endcase
        return {ov, nhi, nlo};
    endfunction

    // Next-state logic for registers, timers and flags
    always_comb begin
        logic [3:0] nib0;
        logic [3:0] nib1;
        logic fall0;
        logic fall1;
        logic en0;
        logic en1;
        logic en_h0;
        logic split;
        logic [16:0] r0;
        logic [16:0] r1;
        dtc_inc_type s;
        logic [1:0] fall_irq;
        r0 = '0;
        r1 = '0;
        s = '0;
        nib0 = state.mode[3:0];
        nib1 = state.mode[7:4];
        next_state = state;
        next_state.rdata = state.rdata;

        // Machine cycle divider
        next_state.mc_tick = 1'b0;
        if (32'(state.mc_cnt) == MC_CYCLES - 1) begin
            next_state.mc_cnt = '0;
            next_state.mc_tick = 1'b1;
        end else begin
            next_state.mc_cnt = 4'(state.mc_cnt + 4'h1);
        end

        // Two-stage synchronisers, then edge history
        next_state.irq_s1 = {ext_irq_pin_one, ext_irq_pin_zero};
        next_state.irq_s2 = state.irq_s1;
        next_state.irq_d = state.irq_s2;
        next_state.cnt_s1 = {count_pin_one, count_pin_zero};
        next_state.cnt_s2 = state.cnt_s1;
        next_state.cnt_d = state.cnt_s2;
        fall0 = state.cnt_d[0] && !state.cnt_s2[0];
        fall1 = state.cnt_d[1] && !state.cnt_s2[1];
        fall_irq = state.irq_d & ~state.irq_s2;

        // Gating uses run bits, mode gate bits and pins, never control bits 3..0
        en0 = dtc_tick(nib0, state.ctrl[`DTC_CTRL_RUN0], state.irq_s2[0],
                       state.mc_tick, fall0);
        en1 = dtc_tick(nib1, state.ctrl[`DTC_CTRL_RUN1], state.irq_s2[1],
                       state.mc_tick, fall1);
        split = nib0[1:0] == 2'(dtc_pkg::DTC_MSPLIT);
        // Split high byte: machine cycles with timer one run bit
        en_h0 = state.ctrl[`DTC_CTRL_RUN1] && state.mc_tick;

        // Timer zero
        next_state.ovf_t0 = 1'b0;
        next_state.ovf_t1 = 1'b0;
        next_state.baud_ovf = 1'b0;
        if (split) begin
            s = dtc_inc(state.tl0, `DTC_BYTE_TOP, en0);
            next_state.tl0 = s.val;
            next_state.ovf_t0 = s.wrap;
            s = dtc_inc(state.th0, `DTC_BYTE_TOP, en_h0);
            next_state.th0 = s.val;
            next_state.ovf_t1 = s.wrap;
        end else begin
            r0 = dtc_step(nib0[1:0], state.tl0, state.th0, en0);
            next_state.tl0 = r0[7:0];
            next_state.th0 = r0[15:8];
            next_state.ovf_t0 = r0[16];
        end

        // Timer one; mode 3 holds, as if stopped
        if (nib1[1:0] != 2'(dtc_pkg::DTC_MSPLIT)) begin
            r1 = dtc_step(nib1[1:0], state.tl1, state.th1,
                          split ? (nib1[`DTC_MODE_CSEL] ? fall1 :
                                   state.mc_tick) : en1);
            next_state.tl1 = r1[7:0];
            next_state.th1 = r1[15:8];
            next_state.baud_ovf = r1[16];
            // In split mode the flag belongs to the high byte of timer zero
            if (!split) begin
                next_state.ovf_t1 = r1[16];
            end
        end

        // Register writes; write happens in the same cycle as counting
        if (wr) begin
            unique case (addr)
                `DTC_ADDR_CTRL: next_state.ctrl = wdata;
                `DTC_ADDR_MODE: next_state.mode = wdata;
                `DTC_ADDR_TL0: next_state.tl0 = wdata;
                `DTC_ADDR_TH0: next_state.th0 = wdata;
                `DTC_ADDR_TL1: next_state.tl1 = wdata;
                `DTC_ADDR_TH1: next_state.th1 = wdata;
                default: next_state.ctrl = next_state.ctrl;
            endcase
        end

        // Vector acknowledge clears overflow flags, and external flags in edge mode only; a new set wins
        if (vec_ack[`DTC_VACK_T0]) begin
            next_state.ctrl[`DTC_CTRL_OVF0] = 1'b0;
        end
        if (vec_ack[`DTC_VACK_T1]) begin
            next_state.ctrl[`DTC_CTRL_OVF1] = 1'b0;
        end
        if (vec_ack[`DTC_VACK_E0] && state.ctrl[`DTC_CTRL_EDG0]) begin
            next_state.ctrl[`DTC_CTRL_EXF0] = 1'b0;
        end
        if (vec_ack[`DTC_VACK_E1] && state.ctrl[`DTC_CTRL_EDG1]) begin
            next_state.ctrl[`DTC_CTRL_EXF1] = 1'b0;
        end

        // Overflow sets
        if (state.ovf_t0) begin
            next_state.ctrl[`DTC_CTRL_OVF0] = 1'b1;
        end
        if (state.ovf_t1) begin
            next_state.ctrl[`DTC_CTRL_OVF1] = 1'b1;
        end

        // External flags: edge latch or level follow
        if (state.ctrl[`DTC_CTRL_EDG0]) begin
            if (fall_irq[0]) begin
                next_state.ctrl[`DTC_CTRL_EXF0] = 1'b1;
            end
        end else begin
            next_state.ctrl[`DTC_CTRL_EXF0] = !state.irq_s2[0];
        end
        if (state.ctrl[`DTC_CTRL_EDG1]) begin
            if (fall_irq[1]) begin
                next_state.ctrl[`DTC_CTRL_EXF1] = 1'b1;
            end
        end else begin
            next_state.ctrl[`DTC_CTRL_EXF1] = !state.irq_s2[1];
        end

        // Read port: data one cycle after strobe
        if (rd) begin
            unique case (addr)
                `DTC_ADDR_CTRL: next_state.rdata = state.ctrl;
                `DTC_ADDR_MODE: next_state.rdata = state.mode;
                `DTC_ADDR_TL0: next_state.rdata = state.tl0;
                `DTC_ADDR_TH0: next_state.rdata = state.th0;
                `DTC_ADDR_TL1: next_state.rdata = state.tl1;
                `DTC_ADDR_TH1: next_state.rdata = state.th1;
                default: next_state.rdata = `DTC_RST_BYTE;
            endcase
        end else begin
            next_state.rdata = `DTC_RST_BYTE;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from flip-flops
    assign rdata = state.rdata;
    assign ovf_flag_zero = state.ctrl[`DTC_CTRL_OVF0];
    assign ovf_flag_one = state.ctrl[`DTC_CTRL_OVF1];
    assign extint_flag_zero = state.ctrl[`DTC_CTRL_EXF0];
    assign extint_flag_one = state.ctrl[`DTC_CTRL_EXF1];
    assign baud_ovf = state.baud_ovf;

endmodule

/* File: test/dtc_timer_assertions.sv */
/* Port-level properties of the dual timer block.
   Assumes a bind to dtc_timer; shadows software writes itself. */
`timescale 1ns/1ps
module dtc_timer_checker #(
    parameter int MC_CYCLES = 12
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [3:0] vec_ack,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ovf_flag_zero,
    input wire logic ovf_flag_one,
    input wire logic extint_flag_zero,
    input wire logic extint_flag_one,
    input wire logic baud_ovf
);
    logic [7:0] ctl_sh; // Last control byte written
    logic [7:0] mode_sh; // Last mode byte written
    logic cw; // Control register write
    assign cw = wr && addr == 8'h88;
    // Track software writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_sh <= 8'h00;
            mode_sh <= 8'h00;
        end else begin
            if (cw) begin
                ctl_sh <= wdata;
            end
            if (wr && addr == 8'h89) begin
                mode_sh <= wdata;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_mode_wr;
        wr && addr == 8'h89;
    endsequence
    property p_rd_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_mode_rb;
        s_mode_wr ##2 (rd && addr == 8'h89) |=> rdata == $past(wdata, 3);
    endproperty
    a_mode_rb: assert property (p_mode_rb)
        else $error("mode readback wrong");
    property p_ovf0_hold;
        ovf_flag_zero && !vec_ack[0] && !cw |=> ovf_flag_zero;
    endproperty
    a_ovf0_hold: assert property (p_ovf0_hold)
        else $error("timer zero flag lost");
    property p_ovf1_hold;
        ovf_flag_one && !vec_ack[2] && !cw |=> ovf_flag_one;
    endproperty
    a_ovf1_hold: assert property (p_ovf1_hold)
        else $error("timer one flag lost");
    property p_lvl_lo;
        (!ctl_sh[0] && !ext_irq_pin_zero)[*5] |-> extint_flag_zero;
    endproperty
    a_lvl_lo: assert property (p_lvl_lo)
        else $error("level request not flagged");
    property p_lvl_hi;
        (!ctl_sh[2] && ext_irq_pin_one)[*5] |-> !extint_flag_one;
    endproperty
    a_lvl_hi: assert property (p_lvl_hi)
        else $error("level flag without request");
    property p_edge_hold;
        ctl_sh[0] && extint_flag_zero && !vec_ack[1] && !cw
            |=> extint_flag_zero;
    endproperty
    a_edge_hold: assert property (p_edge_hold)
        else $error("edge flag lost");
    property p_edge_quiet;
        (ctl_sh[0] && ext_irq_pin_zero)[*5] ##0 (!extint_flag_zero && !cw)
            |=> !extint_flag_zero;
    endproperty
    a_edge_quiet: assert property (p_edge_quiet)
        else $error("edge flag without edge");
    property p_t1_m3;
        (mode_sh[5:4] == 2'b11)[*3] |-> !baud_ovf;
    endproperty
    a_t1_m3: assert property (p_t1_m3)
        else $error("held timer overflowed");
    property p_baud_pulse;
        baud_ovf |=> !baud_ovf;
    endproperty
    a_baud_pulse: assert property (p_baud_pulse)
        else $error("baud pulse too long");
endmodule
bind dtc_timer dtc_timer_checker #(.MC_CYCLES(MC_CYCLES)) u_chk (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .vec_ack(vec_ack),
    .ext_irq_pin_zero(ext_irq_pin_zero), .ext_irq_pin_one(ext_irq_pin_one),
    .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
    .ovf_flag_zero(ovf_flag_zero), .ovf_flag_one(ovf_flag_one),
    .extint_flag_zero(extint_flag_zero), .extint_flag_one(extint_flag_one),
    .baud_ovf(baud_ovf));

/* File: test/dtc_pins_model.sv */
/* Pin-side model: interrupt lines and count inputs, idle high.
   Assumes the bench calls its tasks just after a rising edge. */
`timescale 1ns/1ps
module dtc_pins_model (
    input wire logic clk,
    output logic ext_irq_pin_zero,
    output logic ext_irq_pin_one,
    output logic count_pin_zero,
    output logic count_pin_one
);
    // Lines idle high
    initial begin
        ext_irq_pin_zero = 1'b1;
        ext_irq_pin_one = 1'b1;
        count_pin_zero = 1'b1;
        count_pin_one = 1'b1;
    end
    // Drive an interrupt line level at an edge
    task automatic set_irq(input logic k, input logic v);
        if (k) begin
            ext_irq_pin_one <= v;
        end else begin
            ext_irq_pin_zero <= v;
        end
        @(posedge clk);
    endtask
    // One low pulse, wide enough for the synchroniser; slow stretches it
    task automatic pulse_cnt(input int slow);
        count_pin_zero <= 1'b0;
        repeat (3 + slow) @(posedge clk);
        count_pin_zero <= 1'b1;
        repeat (3 + slow) @(posedge clk);
    endtask
endmodule

/* File: test/dtc_timer_test.sv */
/* Self-checking bench for the dual timer block.
   Assumes a 50 MHz clock and a short machine cycle for speed. */
`timescale 1ns/1ps
module dtc_timer_test;
    logic clk, rstn, wr, rd;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] vec_ack;
    logic pz, po, cz, co, oz, oo, ez, eo, baud_ovf;
    int failures = 0;
    int tests_run = 0;
    dtc_timer #(.MC_CYCLES(2)) DUT (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vec_ack(vec_ack),
        .ext_irq_pin_zero(pz), .ext_irq_pin_one(po), .count_pin_zero(cz),
        .count_pin_one(co), .ovf_flag_zero(oz), .ovf_flag_one(oo),
        .extint_flag_zero(ez), .extint_flag_one(eo), .baud_ovf(baud_ovf));
    dtc_pins_model pins (.clk(clk), .ext_irq_pin_zero(pz),
        .ext_irq_pin_one(po), .count_pin_zero(cz), .count_pin_one(co));
    always #10 clk = ~clk;
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read strobe, then take the data in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a, v);
        chk(v, e);
    endtask
    // Timer zero setup: mode, low, high, then control
    task automatic arm(input logic [7:0] m, l, h, c);
        wr_reg(8'h89, m);
        rd_chk(8'h89, m);
        wr_reg(8'h8a, l);
        wr_reg(8'h8c, h);
        wr_reg(8'h88, c);
    endtask
    task automatic ack(input int i);
        vec_ack <= 4'h1 << i;
        @(posedge clk);
        vec_ack <= 4'h0;
        @(posedge clk);
    endtask
    // Bounded wait for an output flag
    task automatic wait_hi(input int k);
        logic s;
        int n;
        s = 1'b0;
        for (n = 0; n < 3000 && s !== 1'b1; n++) begin
            @(posedge clk);
            #1 s = k == 0 ? oz : k == 1 ? oo : k == 2 ? ez : baud_ovf;
        end
        if (s !== 1'b1) begin
            failures++;
            $display("ERROR t=%0t wait %h exp %h", $time, s, 1'b1);
            wrap_up();
        end
        @(posedge clk);
    endtask
    initial begin
        clk = 0; rstn = 0; wr = 0; rd = 0;
        addr = 8'h00; wdata = 8'h00; vec_ack = 4'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        for (int a = 8'h88; a <= 8'h8d; a++) begin
            rd_chk(a[7:0], 8'h00);
        end
        wr_reg(8'h8f, 8'h5a);
        rd_chk(8'h8f, 8'h00);
        $display("reset test done");
        arm(8'h01, 8'hff, 8'hff, 8'h10);
        wait_hi(0);
        wr_reg(8'h88, 8'h20);
        rd_chk(8'h8c, 8'h00);
        rd_chk(8'h88, 8'h20);
        ack(0);
        rd_chk(8'h88, 8'h00);
        arm(8'h02, 8'hfe, 8'hf0, 8'h10);
        wait_hi(0);
        wr_reg(8'h88, 8'h20);
        rd_chk(8'h8c, 8'hf0);
        rd_reg(8'h8a, v);
        chk({4'h0, v[7:4]}, 8'h0f);
        ack(0);
        arm(8'h00, 8'hff, 8'hff, 8'h10);
        wait_hi(0);
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8c, 8'h00);
        rd_reg(8'h8a, v);
        chk({5'h0, v[7:5]}, 8'h07);
        $display("mode tests done");
        pins.set_irq(0, 0);
        arm(8'h08, 8'h03, 8'h07, 8'h15);
        repeat (40) @(posedge clk);
        rd_chk(8'h8a, 8'h03);
        rd_chk(8'h8c, 8'h07);
        pins.set_irq(0, 1);
        repeat (20) @(posedge clk);
        rd_reg(8'h8a, v);
        chk({7'h0, v !== 8'h03}, 8'h01);
        arm(8'h05, 8'h00, 8'h00, 8'h10);
        for (int i = 0; i < 3; i++) begin
            pins.pulse_cnt(i);
        end
        wr_reg(8'h88, 8'h00);
        rd_chk(8'h8a, 8'h03);
        $display("gate and counter tests done");
        wr_reg(8'h89, 8'h30);
        wr_reg(8'h8b, 8'h40);
        wr_reg(8'h88, 8'h40);
        repeat (20) @(posedge clk);
        rd_chk(8'h8b, 8'h40);
        wr_reg(8'h89, 8'h23);
        wr_reg(8'h8b, 8'hff);
        wr_reg(8'h8d, 8'hff);
        wr_reg(8'h8c, 8'hff);
        wait_hi(3);
        wait_hi(1);
        wr_reg(8'h88, 8'h80);
        ack(2);
        rd_chk(8'h88, 8'h00);
        wr_reg(8'h89, 8'h33);
        repeat (10) @(posedge clk);
        $display("split test done");
        wr_reg(8'h88, 8'h01);
        repeat (6) @(posedge clk);
        pins.set_irq(0, 0);
        wait_hi(2);
        pins.set_irq(0, 1);
        repeat (6) @(posedge clk);
        rd_chk(8'h88, 8'h03);
        ack(1);
        rd_chk(8'h88, 8'h01);
        wr_reg(8'h88, 8'h00);
        pins.set_irq(0, 0);
        pins.set_irq(1, 0);
        repeat (6) @(posedge clk);
        rd_chk(8'h88, 8'h0a);
        pins.set_irq(1, 1);
        repeat (6) @(posedge clk);
        wr_reg(8'h88, 8'h04);
        pins.set_irq(1, 0);
        repeat (6) @(posedge clk);
        rd_chk(8'h88, 8'h0e);
        ack(3);
        rd_chk(8'h88, 8'h06);
        $display("external flag test done");
        wrap_up();
    end
endmodule
